// >>> logic_cluster.sv
// Purpose: One logic cluster of ten cells with shared control signals.
// Assumes: Row clocks and local lines are plain levels sampled on clock.
// Notes: Cluster clocks are edge-detected, so they must stay below half
// the system clock rate; asynchronous controls act one edge later.
`timescale 1ns/1ps
`default_nettype none
module logic_cluster (
  input  wire logic                                     clock,
  input  wire logic                                     rst_n,
  input  wire logic [cluster_pkg::ADDR_W-1:0]           address,
  input  wire logic                                     read,
  input  wire logic                                     write,
  input  wire logic [cluster_pkg::BE_W-1:0]             byteenable,
  input  wire logic [cluster_pkg::DATA_W-1:0]           writedata,
  output logic      [cluster_pkg::DATA_W-1:0]           readdata,
  output logic                                          waitrequest,
  input  wire logic [cluster_pkg::ROW_W-1:0]            row_clock,
  input  wire logic [cluster_pkg::LOC_W-1:0]            local_ctrl,
  input  wire logic                                     device_wide_clear_n,
  input  wire logic [cluster_pkg::CELLS*cluster_pkg::IN_W-1:0] cell_data,
  input  wire logic                                     carry_in,
  input  wire logic                                     lut_chain_in,
  input  wire logic                                     reg_chain_in,
  output logic      [cluster_pkg::CELLS-1:0]            route_out_a,
  output logic      [cluster_pkg::CELLS-1:0]            route_out_b,
  output logic      [cluster_pkg::CELLS-1:0]            local_out,
  output logic                                          lut_chain_out,
  output logic                                          reg_chain_out,
  output logic                                          carry_out
);

  localparam int N  = cluster_pkg::CELLS;
  localparam int SW = cluster_pkg::SEL_W;
  localparam int HALF = cluster_pkg::SEL_PER * cluster_pkg::SEL_W;

  // Picks one control source: row clock or local interconnect line.
  function automatic logic pick_src(
    input logic [cluster_pkg::SEL_W-1:0] sel,
    input logic [cluster_pkg::ROW_W-1:0] row,
    input logic [cluster_pkg::LOC_W-1:0] loc
  );
    logic [cluster_pkg::SEL_SRC-1:0] k;
    k = sel[cluster_pkg::SEL_SRC-1:0];
    pick_src = sel[cluster_pkg::SEL_SRC] ? loc[k] : row[k];
  endfunction : pick_src

  // Applies Avalon byte enables to a stored word.
  function automatic cluster_pkg::data_t merge_be(
    input cluster_pkg::data_t            old,
    input cluster_pkg::data_t            wd,
    input logic [cluster_pkg::BE_W-1:0]  be
  );
    cluster_pkg::data_t r;
    r = old;
    for (int b = 0; b < cluster_pkg::BE_W; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    merge_be = r;
  endfunction : merge_be

  // True when the address falls on one of the cell words.
  function automatic logic cell_hit(
    input logic [cluster_pkg::ADDR_W-1:0] a
  );
    logic [cluster_pkg::ADDR_W-1:0] off;
    off = a - cluster_pkg::OFF_CELL;
    cell_hit = (a >= cluster_pkg::OFF_CELL) &&
               (off[cluster_pkg::IDX_LSB-1:0] == '0) &&
               (off[cluster_pkg::ADDR_W-1:cluster_pkg::IDX_LSB] < N);
  endfunction : cell_hit

  // Cell number addressed by a cell word.
  function automatic logic [cluster_pkg::IDX_W-1:0] cell_idx(
    input logic [cluster_pkg::ADDR_W-1:0] a
  );
    logic [cluster_pkg::ADDR_W-1:0] off;
    off = a - cluster_pkg::OFF_CELL;
    cell_idx = off[cluster_pkg::IDX_LSB +: cluster_pkg::IDX_W];
  endfunction : cell_idx

  // Next state of the configurable register; k is the second input.
  function automatic logic ff_next(
    input cluster_pkg::ff_mode_e mode,
    input logic                  q,
    input logic                  d,
    input logic                  k
  );
    logic r;
    r = q;
    unique case (mode)
      cluster_pkg::FF_D:  r = d;
      cluster_pkg::FF_T:  r = q ^ d;
      cluster_pkg::FF_JK: r = d ? (k ? ~q : 1'b1) : (k ? 1'b0 : q);
      cluster_pkg::FF_SR: r = k ? 1'b0 : (d ? 1'b1 : q);
    endcase
    ff_next = r;
  endfunction : ff_next

  // Register state.
  logic                       ack_q;
  cluster_pkg::data_t         rdata_q;
  logic [cluster_pkg::G_W-1:0] cfg_q;
  logic [2*HALF-1:0]          sel_q;
  cluster_pkg::data_t         cell_cfg_q [N];
  logic [N-1:0]               cell_q;
  logic [1:0]                 clk_prev_q;

  // Combinational nets.
  logic                       req;
  logic                       accept;
  logic                       wr_en;
  logic                       hit;
  logic [cluster_pkg::IDX_W-1:0] idx;
  cluster_pkg::data_t         rd_mux;
  logic [cluster_pkg::NCTRL-1:0] ctrl;
  logic                       clk1;
  logic                       clk2;
  logic                       tick1;
  logic                       tick2;
  logic [N-1:0]               lut_o;
  logic [N:0]                 lut_ch;
  logic [N:0]                 q_ch;
  logic [N:0]                 carry;

  // The slave answers in the second cycle of every request, so the
  // master always sees exactly one wait state; this keeps decode simple.
  assign req         = read | write;
  assign accept      = req & ~ack_q;
  assign waitrequest = accept;
  assign wr_en       = write & ack_q;
  assign hit         = cell_hit(address);
  assign idx         = cell_idx(address);
  assign readdata    = rdata_q;

  // Acknowledge flag for the single wait state.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= accept;
    end
  end

  // Read multiplexer; unmapped words read as zero.
  always_comb begin
    rd_mux = '0;
    if (address == cluster_pkg::OFF_CFG) begin
      rd_mux = cluster_pkg::data_t'(cfg_q);
    end else if (address == cluster_pkg::OFF_STAT) begin
      rd_mux = cluster_pkg::data_t'({carry_out, cell_q});
    end else if (address == cluster_pkg::OFF_SEL_LO) begin
      rd_mux = cluster_pkg::data_t'(sel_q[HALF-1:0]);
    end else if (address == cluster_pkg::OFF_SEL_HI) begin
      rd_mux = cluster_pkg::data_t'(sel_q[2*HALF-1:HALF]);
    end else if (hit) begin
      rd_mux = cell_cfg_q[idx];
    end
  end

  // Read data is captured in the wait cycle and stands at the accept edge.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else if (accept && read) begin
      rdata_q <= rd_mux;
    end
  end

  // Edge-polarity configuration for the two cluster clocks.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cfg_q <= cluster_pkg::CFG_RST;
    end else if (wr_en && address == cluster_pkg::OFF_CFG) begin
      cfg_q <= cluster_pkg::G_W'(merge_be(cluster_pkg::data_t'(cfg_q),
                                          writedata, byteenable));
    end
  end

  // Source selectors for the ten control slots, five per word.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sel_q <= '0;
    end else if (wr_en && address == cluster_pkg::OFF_SEL_LO) begin
      sel_q[HALF-1:0] <= HALF'(merge_be(
        cluster_pkg::data_t'(sel_q[HALF-1:0]), writedata, byteenable));
    end else if (wr_en && address == cluster_pkg::OFF_SEL_HI) begin
      sel_q[2*HALF-1:HALF] <= HALF'(merge_be(
        cluster_pkg::data_t'(sel_q[2*HALF-1:HALF]), writedata, byteenable));
    end
  end

  // Each slot picks a row clock or a local line as its source.
  for (genvar s = 0; s < cluster_pkg::NCTRL; s++) begin : g_ctrl
    assign ctrl[s] = pick_src(sel_q[s*SW +: SW], row_clock, local_ctrl); // R4 R9
  end

  assign clk1 = ctrl[cluster_pkg::C_CLK1];
  assign clk2 = ctrl[cluster_pkg::C_CLK2];

  // Previous cluster clock levels for edge detection.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      clk_prev_q <= 2'h0;
    end else begin
      clk_prev_q <= {clk2, clk1};
    end
  end

  // A clock edge only counts while its own enable is high; one clock can
  // be set to rising and the other to falling to serve both edges.
  assign tick1 = (cfg_q[cluster_pkg::G_FALL1] ? (~clk1 & clk_prev_q[0])
                                              : (clk1 & ~clk_prev_q[0]))
               & ctrl[cluster_pkg::C_ENA1]; // R5 R6 R7
  assign tick2 = (cfg_q[cluster_pkg::G_FALL2] ? (~clk2 & clk_prev_q[1])
                                              : (clk2 & ~clk_prev_q[1]))
               & ctrl[cluster_pkg::C_ENA2]; // R5 R6 R7

  // Chain heads enter at the first cell; subtraction forces carry-in.
  assign lut_ch[0] = lut_chain_in;
  assign q_ch[0]   = reg_chain_in;
  assign carry[0]  = ctrl[cluster_pkg::C_ADD] ? 1'b1 : carry_in; // R19 R20

  // The ten cells, all sharing the same control slots.
  for (genvar i = 0; i < N; i++) begin : g_cell // R1
    cluster_pkg::data_t              c;
    logic [cluster_pkg::IN_W-1:0]    d;
    logic [cluster_pkg::MASK_W-1:0]  mask;
    logic [cluster_pkg::IN_W-1:0]    li;
    logic                            in0;
    logic                            in2;
    logic                            b;
    logic                            sum;
    logic                            ff_d;
    logic                            tick;
    logic                            aclr;

    assign c    = cell_cfg_q[i];
    assign d    = cell_data[i*cluster_pkg::IN_W +: cluster_pkg::IN_W];
    assign mask = c[cluster_pkg::F_MASK +: cluster_pkg::MASK_W];

    // Configuration word for this cell.
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        cell_cfg_q[i] <= cluster_pkg::CELL_RST;
      end else if (wr_en && hit && idx == i) begin
        cell_cfg_q[i] <= merge_be(cell_cfg_q[i], writedata, byteenable);
      end
    end

    // Table inputs may come from the previous cell or own register.
    assign in0 = c[cluster_pkg::F_LUTCH] ? lut_ch[i] : d[0]; // R2
    assign in2 = c[cluster_pkg::F_PACK] ? cell_q[i] : d[2]; // R15
    assign li  = {d[3], in2, d[1], in0};

    // Arithmetic: B is inverted when subtracting.
    assign b   = d[1] ^ ctrl[cluster_pkg::C_ADD]; // R18 R19
    assign sum = d[0] ^ b ^ carry[i]; // R18

    // Non-arithmetic cells pass the carry through unchanged.
    assign carry[i+1] = c[cluster_pkg::F_ARITH]
                      ? ((d[0] & b) | (carry[i] & (d[0] ^ b)))
                      : carry[i];

    // Any function of four inputs is a lookup into the mask.
    assign lut_o[i]  = c[cluster_pkg::F_ARITH] ? sum : mask[li]; // R10
    assign lut_ch[i+1] = lut_o[i]; // R2

    // Register data: own table, or previous register for shifting.
    assign ff_d = c[cluster_pkg::F_CHAIN] ? q_ch[i] : lut_o[i]; // R3 R17
    assign tick = c[cluster_pkg::F_CLKSEL] ? tick2 : tick1; // R5
    assign aclr = c[cluster_pkg::F_CLRSEL] ? ctrl[cluster_pkg::C_CLR2]
                                           : ctrl[cluster_pkg::C_CLR1];

    // Priority: device clear, clear, asynchronous load, then the
    // clocked path; clear and load act without a cluster clock edge.
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        cell_q[i] <= 1'b0;
      end else if (!device_wide_clear_n) begin
        cell_q[i] <= 1'b0; // R22
      end else if (aclr) begin
        cell_q[i] <= 1'b0; // R21
      end else if (c[cluster_pkg::F_ALOAD] && ctrl[cluster_pkg::C_LOAD]) begin
        cell_q[i] <= d[3]; // R8 R12
      end else if (tick) begin
        if (ctrl[cluster_pkg::C_SCLR]) begin
          cell_q[i] <= 1'b0; // R23
        end else if (ctrl[cluster_pkg::C_SLD]) begin
          cell_q[i] <= d[3]; // R23
        end else begin
          cell_q[i] <= ff_next(
            cluster_pkg::ff_mode_e'(c[cluster_pkg::F_MODE +: 2]),
            cell_q[i], ff_d, d[2]); // R11 R12
        end
      end
    end

    assign q_ch[i+1] = cell_q[i]; // R3

    // Each output picks the table or the register independently, so
    // raw and registered results can leave on different pins.
    assign route_out_a[i] = c[cluster_pkg::F_OSEL_A] ? cell_q[i] : lut_o[i]; // R13 R14 R16
    assign route_out_b[i] = c[cluster_pkg::F_OSEL_B] ? cell_q[i] : lut_o[i]; // R14 R16
    assign local_out[i]   = c[cluster_pkg::F_OSEL_L] ? cell_q[i] : lut_o[i]; // R14
  end

  // Chain tails leave from the last cell.
  assign lut_chain_out = lut_ch[N];
  assign reg_chain_out = q_ch[N];
  assign carry_out     = carry[N];

endmodule : logic_cluster
`default_nettype wire

// >>> cluster_pkg.sv
// Purpose: Shared constants for the programmable logic cluster.
// Assumes: One 200 MHz system clock; all cluster inputs are synchronous to it.
// Notes: Register offsets are byte addresses on a 32-bit Avalon-MM slave.
// What this block does
// R1: Ten logic cells share control and chains.
// R2: Lookup-table output chains to the next cell.
// R3: Register output chains into next cell's register.
// R4: Ten cluster-wide control signals at most.
// R5: Each cluster clock paired with its enable.
// R6: Rising and falling edges use both clocks.
// R7: Low enable stops the paired cluster clock.
// R8: Asynchronous load of high acts as preset.
// R9: Controls chosen from row clocks or local lines.
// R10: Four-input table implements any Boolean function.
// R11: Register works as D, T, JK or SR.
// R12: Asynchronous load data is the fourth input.
// R13: Combinational use bypasses the cell register.
// R14: Three outputs, each from table or register.
// R15: Register output may feed own lookup table.
// R16: Registered and raw results drive separate outputs.
// R17: Register chain shifts independent of table logic.
// R18: Add/subtract select gives A+B or A-B.
// R19: Subtract inverts B and forces carry-in one.
// R20: First cell holds LSB, select drives carry.
// R21: Clear wins over simultaneous load or preset.
// R22: Device-wide clear overrides every register control.
// R23: Synchronous clear or load replaces next state.
`default_nettype none
package cluster_pkg;
  localparam int CELLS   = 10;
  localparam int NCTRL   = 10;
  localparam int SEL_W   = 4;
  localparam int SEL_SRC = 3;
  localparam int ROW_W   = 8;
  localparam int LOC_W   = 8;
  localparam int IN_W    = 4;
  localparam int DATA_W  = 32;
  localparam int ADDR_W  = 8;
  localparam int BE_W    = 4;
  localparam int SEL_PER = 5;
  typedef logic [DATA_W-1:0] data_t;
  // Byte addresses of the register words.
  localparam logic [ADDR_W-1:0] OFF_CFG    = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STAT   = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_SEL_LO = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_SEL_HI = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_CELL   = 8'h40;
  localparam int IDX_LSB = 2;
  localparam int IDX_W   = 4;
  // Global configuration bits.
  localparam int G_FALL1 = 0;
  localparam int G_FALL2 = 1;
  localparam int G_W     = 2;
  // Cell configuration fields.
  localparam int F_MASK   = 0;
  localparam int MASK_W   = 16;
  localparam int F_MODE   = 16;
  localparam int F_CLKSEL = 18;
  localparam int F_CLRSEL = 19;
  localparam int F_ALOAD  = 20;
  localparam int F_CHAIN  = 21;
  localparam int F_LUTCH  = 22;
  localparam int F_PACK   = 23;
  localparam int F_OSEL_A = 24;
  localparam int F_OSEL_B = 25;
  localparam int F_OSEL_L = 26;
  localparam int F_ARITH  = 27;
  localparam int STAT_CO  = 10;
  localparam data_t CELL_RST = 32'h0000_0000;
  localparam logic [G_W-1:0] CFG_RST = 2'h0;
  // Control signal slots.
  localparam int C_CLK1 = 0;
  localparam int C_ENA1 = 1;
  localparam int C_CLK2 = 2;
  localparam int C_ENA2 = 3;
  localparam int C_CLR1 = 4;
  localparam int C_CLR2 = 5;
  localparam int C_SCLR = 6;
  localparam int C_LOAD = 7;
  localparam int C_SLD  = 8;
  localparam int C_ADD  = 9;
  typedef enum logic [1:0] {
    FF_D  = 2'b00,
    FF_T  = 2'b01,
    FF_JK = 2'b10,
    FF_SR = 2'b11
  } ff_mode_e;
endpackage : cluster_pkg
`default_nettype wire

// >>> fabric_model.sv
// Purpose: Neighbouring fabric that drives the row clock lines of the cluster.
// Assumes: One system clock; a request is a single-cycle pulse.
// Notes: Line 0 is a cluster clock, line 1 its enable, the rest idle low.
`timescale 1ns/1ps
`default_nettype none
module fabric_model (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       pulse,
  input  wire logic       ena,
  output logic      [7:0] row_clock
);
  logic [2:0] cnt_q;

  // Each request gives two cycles high then two low, so the cluster never sees a short phase.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_q <= 3'h0;
    end else if (pulse && cnt_q == 3'h0) begin
      cnt_q <= 3'h4;
    end else if (cnt_q != 3'h0) begin
      cnt_q <= cnt_q - 3'h1;
    end
  end

  // The clock stands still low between requests.
  assign row_clock = {6'h00, ena, cnt_q > 3'h2};
endmodule : fabric_model
`default_nettype wire

// >>> logic_cluster_monitor.sv
// Purpose: Port-level assertions on the logic cluster.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Cell configuration is not visible, so only bus, reset, clear and quiet-input hold relations are checked.
`timescale 1ns/1ps
`default_nettype none
module logic_cluster_monitor (
  input wire logic [cluster_pkg::ADDR_W-1:0]                   address,
  input wire logic                                             clock,
  input wire logic                                             rst_n,
  input wire logic                                             read,
  input wire logic                                             write,
  input wire logic [cluster_pkg::DATA_W-1:0]                   readdata,
  input wire logic                                             waitrequest,
  input wire logic [cluster_pkg::ROW_W-1:0]                    row_clock,
  input wire logic [cluster_pkg::LOC_W-1:0]                    local_ctrl,
  input wire logic                                             device_wide_clear_n,
  input wire logic [cluster_pkg::CELLS*cluster_pkg::IN_W-1:0] cell_data,
  input wire logic [cluster_pkg::CELLS-1:0]                    route_out_a,
  input wire logic [cluster_pkg::CELLS-1:0]                    local_out,
  input wire logic                                             reg_chain_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Bus handshake: exactly one wait cycle per transfer.
  one_wait_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("Request waited more than one cycle.");
  first_wait_a: assert property ($rose(read || write) |-> waitrequest)
    else $error("Request answered without a wait cycle.");
  idle_ready_a: assert property (!(read || write) |-> !waitrequest)
    else $error("Wait raised with no request.");
  rdata_hold_a: assert property (!(read && waitrequest) |=> $stable(readdata))
    else $error("Read data moved without a read.");
  gap_read_a: assert property (read && !waitrequest && address inside {[8'h10:8'h3f]}
    |-> readdata == '0) else $error("Unmapped read not zero.");
  stat_read_a: assert property (read && !waitrequest && address == cluster_pkg::OFF_STAT
    |-> readdata[31:11] == '0 && readdata[9] == $past(reg_chain_out))
    else $error("Status word wrong.");
  // Clears and quiet inputs.
  dev_clear_a: assert property (!device_wide_clear_n |=> !reg_chain_out)
    else $error("Device clear left a register set.");
  reset_quiet_a: assert property ($rose(rst_n) |-> route_out_a == '0 && local_out == '0)
    else $error("Outputs not quiet after reset.");
  chain_hold_a: assert property (($stable(row_clock) && $stable(local_ctrl) &&
    $stable(cell_data) && device_wide_clear_n && !write)[*2] |=> $stable(reg_chain_out))
    else $error("Register changed with no cause.");
endmodule : logic_cluster_monitor

bind logic_cluster logic_cluster_monitor mon (.clock(clock), .rst_n(rst_n),
  .address(address), .read(read), .write(write), .readdata(readdata),
  .waitrequest(waitrequest), .row_clock(row_clock), .local_ctrl(local_ctrl),
  .device_wide_clear_n(device_wide_clear_n), .cell_data(cell_data),
  .route_out_a(route_out_a), .local_out(local_out), .reg_chain_out(reg_chain_out));
`default_nettype wire

// >>> testbench.sv
// Purpose: Self-checking bench for the logic cluster.
// Assumes: Cells are programmed over the register bus before use.
// Notes: Each tick is one full cluster clock period from the fabric model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic [39:0] cell_data;
  logic [31:0] writedata, readdata, rdata_v;
  logic [10:0] exp_v;
  logic [9:0]  route_out_a, route_out_b, local_out, a_v, b_v;
  logic [7:0]  address, row_clock, local_ctrl;
  logic [3:0]  byteenable;
  logic        clock, rst_n, read, write, waitrequest, device_wide_clear_n;
  logic        lut_chain_in, reg_chain_in, lut_chain_out, reg_chain_out, carry_out;
  logic        pulse, ena, carry_in;
  int          err_count = 0;
  int          n_compared = 0;
  int          cyc = 0;
  logic [2:0]  mode_exp [4] = '{3'b011, 3'b001, 3'b001, 3'b111};
  logic [4:0]  async_seq [6] = '{5'b10111, 5'b10100, 5'b10111, 5'b11110, 5'b10111, 5'b00110};
  logic [9:0]  op_a [3] = '{10'h2f5, 10'h001, 10'h000};
  logic [9:0]  op_b [3] = '{10'h10b, 10'h3ff, 10'h001};

  logic_cluster uut (.clock(clock), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .row_clock(row_clock), .local_ctrl(local_ctrl),
    .device_wide_clear_n(device_wide_clear_n), .cell_data(cell_data), .carry_in(carry_in),
    .lut_chain_in(lut_chain_in), .reg_chain_in(reg_chain_in), .route_out_a(route_out_a),
    .route_out_b(route_out_b), .local_out(local_out), .lut_chain_out(lut_chain_out),
    .reg_chain_out(reg_chain_out), .carry_out(carry_out));
  fabric_model fab (.clock(clock), .rst_n(rst_n), .pulse(pulse), .ena(ena),
    .row_clock(row_clock));

  // Free-running 200 MHz clock.
  always #2.5 clock = ~clock;

  // A hang is cut short well past the expected run length.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      $display("FAIL %0t timeout", $time);
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // The request is held until the edge that sees waitrequest low; an edge passes after release.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    @(posedge clock);
    while (waitrequest !== 1'b0) @(posedge clock);
    rdata_v = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clock);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdata_v, e);
  endtask : rd

  function automatic logic [7:0] ca(input int i);
    return cluster_pkg::OFF_CELL + 8'(4 * i);
  endfunction : ca

  task automatic all_cells(input logic [31:0] d);
    for (int i = 0; i < 10; i++) wr(ca(i), d);
  endtask : all_cells

  // Six cycles cover the rising and the falling edge of one tick.
  task automatic tick();
    pulse <= 1'b1;
    @(posedge clock);
    pulse <= 1'b0;
    repeat (6) @(posedge clock);
  endtask : tick

  task automatic dev_clear();
    device_wide_clear_n <= 1'b0;
    @(posedge clock);
    device_wide_clear_n <= 1'b1;
    @(posedge clock);
  endtask : dev_clear

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  initial begin
    clock = 1'b0;
    {rst_n, read, write, pulse, ena, lut_chain_in, reg_chain_in, carry_in} = '0;
    {address, writedata, local_ctrl, cell_data} = '0;
    device_wide_clear_n = 1'b1;
    byteenable = 4'hf;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    // Reset values, an unmapped hole, and selectors: row 0 clocks, row 1 enables, local 0..5.
    rd(ca(9), 32'h0);
    wr(8'h20, 32'hffff_ffff);
    rd(8'h20, 32'h0);
    wr(cluster_pkg::OFF_CFG, 32'hffff_ffff);
    rd(cluster_pkg::OFF_CFG, 32'h3);
    wr(cluster_pkg::OFF_CFG, 32'h0);
    wr(cluster_pkg::OFF_SEL_LO, 32'h0008_1010);
    wr(cluster_pkg::OFF_SEL_HI, 32'h000d_cba9);
    rd(cluster_pkg::OFF_SEL_HI, 32'h000d_cba9);
    // Odd parity in the table, every input combination.
    wr(ca(0), 32'h0000_6996);
    for (int i = 0; i < 16; i++) begin
      cell_data[3:0] <= 4'(i);
      @(posedge clock);
      chk(32'({route_out_a[0], route_out_b[0], local_out[0]}), 32'({3{^4'(i)}}));
    end
    // Registered result on one output, raw on another; enable gates the clock.
    wr(ca(0), 32'h0100_6996);
    cell_data[3:0] <= 4'h1;
    tick();
    chk(32'({route_out_a[0], route_out_b[0]}), 32'h1);
    ena <= 1'b1;
    tick();
    chk(32'({route_out_a[0], route_out_b[0]}), 32'h3);
    wr(cluster_pkg::OFF_CFG, 32'h1);
    cell_data[3:0] <= 4'h3;
    tick();
    chk(32'({route_out_a[0], route_out_b[0]}), 32'h0);
    wr(cluster_pkg::OFF_CFG, 32'h0);
    // Own register feeds the table as its inverse, so the cell toggles.
    wr(ca(0), 32'h0180_0f0f);
    for (int t = 1; t < 3; t++) begin
      tick();
      chk(32'({route_out_a[0], route_out_b[0]}), 32'({t[0], ~t[0]}));
    end
    // Register kinds: table one, one, zero; the second input is K or R.
    for (int m = 0; m < 4; m++) begin
      dev_clear();
      rd(cluster_pkg::OFF_STAT, 32'h0);
      cell_data[2] <= (m == 2);
      for (int t = 0; t < 3; t++) begin
        wr(ca(0), {8'h01, 6'h00, 2'(m), (t < 2) ? 16'hffff : 16'h0000});
        tick();
        chk(32'(route_out_a[0]), 32'(mode_exp[m][t]));
      end
    end
    // Asynchronous load, preset, clear priority and device clear.
    wr(ca(0), 32'h0010_0000);
    for (int s = 0; s < 6; s++) begin
      {device_wide_clear_n, local_ctrl[0], local_ctrl[3], cell_data[3]} <= async_seq[s][4:1];
      @(posedge clock);
      rd(cluster_pkg::OFF_STAT, 32'(async_seq[s][0]));
    end
    {device_wide_clear_n, local_ctrl} <= {1'b1, 8'h00};
    // Synchronous clear then synchronous load against the table value.
    wr(ca(0), 32'h0100_ffff);
    tick();
    chk(32'(route_out_a[0]), 32'h1);
    local_ctrl[2] <= 1'b1;
    tick();
    chk(32'(route_out_a[0]), 32'h0);
    local_ctrl[2] <= 1'b0;
    local_ctrl[4] <= 1'b1;
    wr(ca(0), 32'h0100_0000);
    tick();
    chk(32'(route_out_a[0]), 32'h1);
    local_ctrl[4] <= 1'b0;
    // Shift register through all ten cells while the tables pass input zero.
    all_cells(32'h0420_aaaa);
    cell_data <= 40'h10_1010_1010;
    dev_clear();
    exp_v = '0;
    for (int i = 0; i < 10; i++) begin
      exp_v[9:0] = {exp_v[8:0], 1'((10'h2d3 >> i) & 10'h1)};
      reg_chain_in <= exp_v[0];
      tick();
      chk(32'({reg_chain_out, local_out, route_out_b}), 32'({exp_v[9:0], 10'h2aa}) |
        32'({exp_v[9], 20'h0}));
    end
    // Table chain from the head to the tail.
    all_cells(32'h0040_aaaa);
    for (int b = 0; b < 2; b++) begin
      lut_chain_in <= b[0];
      @(posedge clock);
      chk(32'({lut_chain_out, route_out_a}), 32'({11{b[0]}}));
    end
    // Add then subtract, least significant bit in cell zero.
    all_cells(32'h0800_0000);
    for (int p = 0; p < 6; p++) begin
      a_v = op_a[p % 3];
      b_v = op_b[p % 3];
      local_ctrl[5] <= (p > 2);
      // Carry-in counts when adding; subtracting must force it regardless.
      carry_in <= (p == 2);
      for (int i = 0; i < 10; i++) cell_data[4*i +: 2] <= {b_v[i], a_v[i]};
      exp_v = (p > 2) ? {1'b0, a_v} + {1'b0, ~b_v} + 11'h1
                      : {1'b0, a_v} + {1'b0, b_v} + 11'(p == 2);
      @(posedge clock);
      chk(32'({carry_out, route_out_a}), 32'(exp_v));
    end
    results();
  end
endmodule : testbench
`default_nettype wire
